// ### hw/adc_scan_and_pin_config.sv
// scan select and pin mode registers with apb slave and pin read path
`timescale 1ns/1ps
module adc_scan_and_pin_config #(
   parameter int NUM_INPUTS = 32
) (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire adc_cfg_pkg::apb_req_t apb_req,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [1:0]            conv_done,
   input  wire logic [31:0]           pin_in,
   output logic [31:0]                pin_digital,
   output logic [31:0]                mux_ground_c1,
   output logic [15:0]                mux_ground_c2,
   output logic [31:0]                pin_read,
   output adc_cfg_pkg::mux_ctrl_t     mux_ctrl_c1,
   output adc_cfg_pkg::mux_ctrl_t     mux_ctrl_c2
);
   localparam int NC = adc_cfg_pkg::NUM_CONV;
   localparam int HW = adc_cfg_pkg::HALF_W;
   localparam int C2_INPUTS = (NUM_INPUTS < HW) ? NUM_INPUTS : HW;

   logic [HW-1:0]   scan_hi_r [NC];
   logic [HW-1:0]   scan_lo_r [NC];
   logic [HW-1:0]   pin_lo_r  [NC];
   logic [HW-1:0]   pin_hi_r;
   logic [31:0]     ctrl_r;
   logic [31:0]     prdata_r;
   logic            pslverr_r;
   logic [31:0]     rd_val;
   logic            rd_hit;
   logic            wr_fire;
   logic            setup_rd;
   logic [7:0]      word_addr;
   logic [31:0]     status_val;
   logic [31:0]     sync1_r;
   logic [31:0]     sync2_r;
   logic [31:0]     sync3_r;
   logic [31:0]     pin_filt_r;
   logic [31:0]     pin_read_r;
   adc_cfg_pkg::mux_ctrl_t mux_ctrl [NC];

   assign word_addr = {apb_req.paddr[7:2], 2'b00};
   assign setup_rd  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign wr_fire   = apb_req.psel && apb_req.penable && apb_req.pwrite
                      && rd_hit;
   // zero wait states: read data is captured in the setup cycle
   assign pready    = 1'b1;
   assign prdata    = prdata_r;
   assign pslverr   = pslverr_r;

   // status word, one field group per converter
   always_comb begin
      status_val = 32'h0000_0000;
      for (int k = 0; k < NC; k++) begin
         status_val[k*adc_cfg_pkg::CONV_STRIDE
                    + adc_cfg_pkg::STAT_SEL_LSB +: adc_cfg_pkg::SEL_W]
            = mux_ctrl[k].ch0_pos_sel;
         status_val[k*adc_cfg_pkg::CONV_STRIDE
                    + adc_cfg_pkg::STAT_SCANNING] = mux_ctrl[k].scanning;
         status_val[k*adc_cfg_pkg::CONV_STRIDE
                    + adc_cfg_pkg::STAT_NEG_REF]  = mux_ctrl[k].neg_ref;
      end
   end

   // read decode; the second converter's high pin slot is a hole
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (word_addr)
         adc_cfg_pkg::OFS_C1_SCAN_HIGH: rd_val[HW-1:0] = scan_hi_r[0];
         adc_cfg_pkg::OFS_C1_SCAN_LOW:  rd_val[HW-1:0] = scan_lo_r[0];
         adc_cfg_pkg::OFS_C1_PIN_HIGH:  rd_val[HW-1:0] = pin_hi_r;
         adc_cfg_pkg::OFS_C1_PIN_LOW:   rd_val[HW-1:0] = pin_lo_r[0];
         adc_cfg_pkg::OFS_C2_SCAN_HIGH: rd_val[HW-1:0] = scan_hi_r[1];
         adc_cfg_pkg::OFS_C2_SCAN_LOW:  rd_val[HW-1:0] = scan_lo_r[1];
         adc_cfg_pkg::OFS_C2_PIN_LOW:   rd_val[HW-1:0] = pin_lo_r[1];
         adc_cfg_pkg::OFS_CTRL:         rd_val = ctrl_r;
         adc_cfg_pkg::OFS_STATUS:       rd_val = status_val;
         adc_cfg_pkg::OFS_C2_PIN_HIGH:  rd_hit = 1'b0;
         default:                       rd_hit = 1'b0;
      endcase
      if (apb_req.pwrite && (word_addr == adc_cfg_pkg::OFS_STATUS)) begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (apb_req.psel && !apb_req.penable) begin
         prdata_r  <= setup_rd ? rd_val : 32'h0000_0000;
         pslverr_r <= !rd_hit;
      end
   end

   // scan select storage, every bit kept even for absent inputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < NC; k++) begin
            scan_hi_r[k] <= adc_cfg_pkg::RST_HALF;
            scan_lo_r[k] <= adc_cfg_pkg::RST_HALF;
         end
      end else if (wr_fire) begin
         case (word_addr)
            adc_cfg_pkg::OFS_C1_SCAN_HIGH:
               scan_hi_r[0] <= apb_req.pwdata[HW-1:0];
            adc_cfg_pkg::OFS_C1_SCAN_LOW:
               scan_lo_r[0] <= apb_req.pwdata[HW-1:0];
            adc_cfg_pkg::OFS_C2_SCAN_HIGH:
               scan_hi_r[1] <= apb_req.pwdata[HW-1:0];
            adc_cfg_pkg::OFS_C2_SCAN_LOW:
               scan_lo_r[1] <= apb_req.pwdata[HW-1:0];
            default: begin
            end
         endcase
      end
   end

   // pin mode storage
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_hi_r    <= adc_cfg_pkg::RST_HALF;
         pin_lo_r[0] <= adc_cfg_pkg::RST_HALF;
         pin_lo_r[1] <= adc_cfg_pkg::RST_HALF;
      end else if (wr_fire) begin
         case (word_addr)
            adc_cfg_pkg::OFS_C1_PIN_HIGH:
               pin_hi_r <= apb_req.pwdata[HW-1:0];
            adc_cfg_pkg::OFS_C1_PIN_LOW:
               pin_lo_r[0] <= apb_req.pwdata[HW-1:0];
            adc_cfg_pkg::OFS_C2_PIN_LOW:
               pin_lo_r[1] <= apb_req.pwdata[HW-1:0];
            default: begin
            end
         endcase
      end
   end

   // scan enable and fixed channel 0 selection per converter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= adc_cfg_pkg::RST_CTRL;
      end else if (wr_fire && (word_addr == adc_cfg_pkg::OFS_CTRL)) begin
         ctrl_r <= apb_req.pwdata;
      end
   end

   genvar k;
   generate
      for (k = 0; k < NC; k++) begin : g_conv
         adc_scan_seq #(
            .NUM_INPUTS (k == 0 ? NUM_INPUTS : C2_INPUTS)
         ) i_adc_scan_seq (
            .mclk        (mclk),
            .reset_n     (reset_n),
            .scan_en     (ctrl_r[k*adc_cfg_pkg::CONV_STRIDE
                                 + adc_cfg_pkg::CTRL_SCAN_EN]),
            .scan_select ({scan_hi_r[k], scan_lo_r[k]}),
            .fixed_sel   (ctrl_r[k*adc_cfg_pkg::CONV_STRIDE
                                 + adc_cfg_pkg::CTRL_FIXED_LSB
                                 +: adc_cfg_pkg::SEL_W]),
            .conv_done   (conv_done[k]),
            .mux_ctrl    (mux_ctrl[k])
         );
      end
   endgenerate

   assign mux_ctrl_c1 = mux_ctrl[0];
   assign mux_ctrl_c2 = mux_ctrl[1];

   // per pin mode, ground switch and filtered read path
   genvar i;
   generate
      for (i = 0; i < adc_cfg_pkg::FULL_W; i++) begin : g_pin
         logic cfg_bit;
         if (i < HW) begin : g_low
            assign cfg_bit = pin_lo_r[0][i] | pin_lo_r[1][i];
         end else begin : g_high
            assign cfg_bit = pin_hi_r[i-HW];
         end
         if (i < NUM_INPUTS) begin : g_live
            assign pin_digital[i]   = cfg_bit;
            assign mux_ground_c1[i] = cfg_bit;
         end else begin : g_absent
            assign pin_digital[i]   = 1'b0;
            assign mux_ground_c1[i] = 1'b0;
         end
         if (i < HW) begin : g_c2
            if (i < C2_INPUTS) begin : g_c2_live
               assign mux_ground_c2[i] = cfg_bit;
            end else begin : g_c2_absent
               assign mux_ground_c2[i] = 1'b0;
            end
         end

         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_r[i]    <= 1'b0;
               sync2_r[i]    <= 1'b0;
               sync3_r[i]    <= 1'b0;
               pin_filt_r[i] <= 1'b0;
               pin_read_r[i] <= 1'b0;
            end else begin
               sync1_r[i] <= pin_in[i];
               sync2_r[i] <= sync1_r[i];
               sync3_r[i] <= sync2_r[i];
               if (sync2_r[i] == sync3_r[i]) begin
                  pin_filt_r[i] <= sync3_r[i];
               end
               // analog pins read as zero
               pin_read_r[i] <= pin_digital[i] & pin_filt_r[i];
            end
         end

         chk_analog_read_off: assert property (
            @(posedge mclk) disable iff (!reset_n)
            !pin_digital[i] |=> !pin_read[i])
            else $error("analog pin leaks onto read path");

         chk_digital_read_on: assert property (
            @(posedge mclk) disable iff (!reset_n)
            pin_digital[i] && $stable(pin_digital[i])
            |=> (pin_read[i] == $past(pin_filt_r[i])))
            else $error("digital pin read path not enabled");
      end
   endgenerate

   assign pin_read = pin_read_r;

   chk_write_lands: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (word_addr == adc_cfg_pkg::OFS_C1_SCAN_LOW)
      |=> scan_lo_r[0] == $past(apb_req.pwdata[HW-1:0]))
      else $error("scan low write did not land");

   chk_reset_clear: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> (pin_hi_r == 16'h0000) && (ctrl_r == 32'h0)
      && (pin_lo_r[0] == 16'h0000) && (scan_hi_r[0] == 16'h0000)
      && (pin_digital == 32'h0000_0000))
      else $error("registers not clear after reset");

   chk_high_half_read: assert property (
      @(posedge mclk) disable iff (!reset_n)
      setup_rd && (word_addr == adc_cfg_pkg::OFS_C1_SCAN_HIGH)
      |=> prdata == {16'h0000, $past(scan_hi_r[0])} && !pslverr)
      else $error("high scan half read wrong");

   chk_no_second_high: assert property (
      @(posedge mclk) disable iff (!reset_n)
      apb_req.psel && !apb_req.penable
      && (word_addr == adc_cfg_pkg::OFS_C2_PIN_HIGH)
      |=> pslverr && (prdata == 32'h0000_0000))
      else $error("second converter high pin slot answered");

   chk_shared_low: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (pin_lo_r[1][0] || pin_lo_r[0][0]) |-> pin_digital[0])
      else $error("low pin register of a converter ignored");

   chk_absent_pins: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (NUM_INPUTS < 32) |-> (pin_digital[31] == 1'b0)
      && (mux_ground_c1[31] == 1'b0))
      else $error("absent pin affected by its config bit");

   chk_pin_high_lands: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (word_addr == adc_cfg_pkg::OFS_C1_PIN_HIGH)
      |=> pin_hi_r == $past(apb_req.pwdata[HW-1:0]))
      else $error("high pin write did not land");

   chk_c2_low_lands: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (word_addr == adc_cfg_pkg::OFS_C2_PIN_LOW)
      |=> pin_lo_r[1] == $past(apb_req.pwdata[HW-1:0]))
      else $error("second converter low pin write did not land");

   chk_hole_write_dropped: assert property (
      @(posedge mclk) disable iff (!reset_n)
      apb_req.psel && apb_req.penable && apb_req.pwrite
      && (word_addr == adc_cfg_pkg::OFS_C2_PIN_HIGH)
      |=> $stable(pin_hi_r) && $stable(pin_lo_r[0]) && $stable(pin_lo_r[1]))
      else $error("write to missing high pin slot changed a register");

   chk_upper_half_zero: assert property (
      @(posedge mclk) disable iff (!reset_n)
      setup_rd && (word_addr < adc_cfg_pkg::OFS_CTRL)
      |=> prdata[31:HW] == 16'h0000)
      else $error("upper half of a 16 bit register read not zero");

   chk_scan_needs_enable: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !ctrl_r[adc_cfg_pkg::CTRL_SCAN_EN] |=> !mux_ctrl_c1.scanning)
      else $error("converter 1 scans while its scan enable is clear");

   chk_ground_shared: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (pin_lo_r[0][0] || pin_lo_r[1][0])
      |-> mux_ground_c1[0] && mux_ground_c2[0])
      else $error("grounding of a shared low pin missing");

   chk_analog_sampled: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !pin_digital[0] |-> !mux_ground_c1[0] && !mux_ground_c2[0])
      else $error("analog pin grounded at the converter input");

   chk_ctrl_lands: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (word_addr == adc_cfg_pkg::OFS_CTRL)
      |=> ctrl_r == $past(apb_req.pwdata))
      else $error("control write did not land");

   chk_scan_high_lands: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_fire && (word_addr == adc_cfg_pkg::OFS_C2_SCAN_HIGH)
      |=> scan_hi_r[1] == $past(apb_req.pwdata[HW-1:0]))
      else $error("second converter high scan write did not land");

   // status is read only, a write to it is answered with an error
   chk_status_read_only: assert property (
      @(posedge mclk) disable iff (!reset_n)
      apb_req.psel && !apb_req.penable && apb_req.pwrite
      && (word_addr == adc_cfg_pkg::OFS_STATUS)
      |=> pslverr)
      else $error("write to status word not refused");
endmodule

// ### hw/adc_cfg_pkg.sv
// shared constants and types for the converter scan and pin setup block
package adc_cfg_pkg;
   localparam int NUM_CONV = 2;
   localparam int ADDR_W   = 8;
   localparam int SEL_W    = 5;
   localparam int HALF_W   = 16;
   localparam int FULL_W   = 32;

   localparam logic [7:0] OFS_C1_SCAN_HIGH = 8'h00;
   localparam logic [7:0] OFS_C1_SCAN_LOW  = 8'h04;
   localparam logic [7:0] OFS_C1_PIN_HIGH  = 8'h08;
   localparam logic [7:0] OFS_C1_PIN_LOW   = 8'h0C;
   localparam logic [7:0] OFS_C2_SCAN_HIGH = 8'h10;
   localparam logic [7:0] OFS_C2_SCAN_LOW  = 8'h14;
   localparam logic [7:0] OFS_C2_PIN_HIGH  = 8'h18;
   localparam logic [7:0] OFS_C2_PIN_LOW   = 8'h1C;
   localparam logic [7:0] OFS_CTRL         = 8'h20;
   localparam logic [7:0] OFS_STATUS       = 8'h24;

   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;

   // per converter fields, converter k starts at k*CONV_STRIDE
   localparam int CONV_STRIDE     = 16;
   localparam int CTRL_FIXED_LSB  = 0;
   localparam int CTRL_SCAN_EN    = 8;
   localparam int STAT_SEL_LSB    = 0;
   localparam int STAT_SCANNING   = 5;
   localparam int STAT_NEG_REF    = 6;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [SEL_W-1:0] ch0_pos_sel;
      logic             neg_ref;
      logic             scanning;
   } mux_ctrl_t;

   typedef enum logic [1:0] {
      SEQ_FIXED = 2'b01,
      SEQ_SCAN  = 2'b10
   } seq_state_t;
endpackage

// ### hw/adc_scan_seq.sv
// channel 0 positive input sequencer for one converter
`timescale 1ns/1ps
module adc_scan_seq #(
   parameter int NUM_INPUTS = 32
) (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire logic                  scan_en,
   input  wire logic [31:0]           scan_select,
   input  wire logic [4:0]            fixed_sel,
   input  wire logic                  conv_done,
   output adc_cfg_pkg::mux_ctrl_t     mux_ctrl
);
   adc_cfg_pkg::seq_state_t state_r;
   adc_cfg_pkg::seq_state_t state_nxt;
   logic [4:0]              sel_r;
   logic [4:0]              sel_nxt;
   logic                    neg_ref_r;

   // first selected index above cur, wrapping past 31
   function automatic logic [4:0] next_of(input logic [4:0]  cur,
                                          input logic [31:0] sel);
      logic [4:0] idx;
      logic       found;
      next_of = cur;
      found   = 1'b0;
      for (int i = 1; i <= 32; i++) begin
         idx = cur + 5'(i);
         if (!found && sel[idx]) begin
            next_of = idx;
            found   = 1'b1;
         end
      end
   endfunction

   always_comb begin
      state_nxt = state_r;
      sel_nxt   = sel_r;
      case (state_r)
         adc_cfg_pkg::SEQ_FIXED: begin
            sel_nxt = fixed_sel;
            if (scan_en && (scan_select != 32'h0000_0000)) begin
               state_nxt = adc_cfg_pkg::SEQ_SCAN;
               sel_nxt   = next_of(5'h1F, scan_select);
            end
         end
         adc_cfg_pkg::SEQ_SCAN: begin
            if (!scan_en || (scan_select == 32'h0000_0000)) begin
               state_nxt = adc_cfg_pkg::SEQ_FIXED;
               sel_nxt   = fixed_sel;
            end else if (conv_done || !scan_select[sel_r]) begin
               sel_nxt = next_of(sel_r, scan_select);
            end
         end
         default: begin
            state_nxt = adc_cfg_pkg::SEQ_FIXED;
            sel_nxt   = fixed_sel;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= adc_cfg_pkg::SEQ_FIXED;
         sel_r     <= 5'h00;
         neg_ref_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         sel_r     <= sel_nxt;
         neg_ref_r <= (int'(sel_nxt) >= NUM_INPUTS);
      end
   end

   assign mux_ctrl.ch0_pos_sel = sel_r;
   assign mux_ctrl.neg_ref     = neg_ref_r;
   assign mux_ctrl.scanning    = (state_r == adc_cfg_pkg::SEQ_SCAN);

   chk_skip_unselected: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (state_r == adc_cfg_pkg::SEQ_SCAN) && $stable(scan_select)
      |-> scan_select[sel_r])
      else $error("scan sits on an unselected input");

   chk_absent_neg_ref: assert property (
      @(posedge mclk) disable iff (!reset_n)
      mux_ctrl.neg_ref == (int'(mux_ctrl.ch0_pos_sel) >= NUM_INPUTS))
      else $error("absent input not mapped to negative reference");

   chk_fixed_when_off: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !scan_en |=> (sel_r == $past(fixed_sel)) && !mux_ctrl.scanning)
      else $error("fixed selection not used while scan is off");

   chk_scan_advances: assert property (
      @(posedge mclk) disable iff (!reset_n)
      mux_ctrl.scanning && scan_en && conv_done
      && $stable(scan_select) && ($countones(scan_select) > 1)
      |=> (sel_r == next_of($past(sel_r), $past(scan_select))))
      else $error("scan did not step to next selected input");
endmodule

// ### bench/adc_far_side.sv
// far side model: converter conversion timing and port pin pads
`timescale 1ns/1ps
module adc_far_side #(
   parameter int CONV_LAT = 3
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [1:0]  conv_req,
   input  wire logic [31:0] pin_level,
   input  wire logic [31:0] pin_digital,
   output logic [1:0]       conv_done,
   output logic [31:0]      pin_in
);
   logic [1:0]  stage_r [CONV_LAT];
   logic [31:0] noise_r;

   // a one-cycle request comes back as a one-cycle done pulse
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CONV_LAT; i++) stage_r[i] <= 2'b00;
      end else begin
         stage_r[0] <= conv_req;
         for (int i = 1; i < CONV_LAT; i++) stage_r[i] <= stage_r[i-1];
      end
   end
   assign conv_done = stage_r[CONV_LAT-1];

   // analog pads carry no stable logic level, so they toggle every cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) noise_r <= 32'h5555_5555;
      else          noise_r <= ~noise_r;
   end
   assign pin_in = (pin_level & pin_digital) | (noise_r & ~pin_digital);
endmodule

// ### bench/adc_scan_and_pin_config_test.sv
// register, pin mode and scan sequence tests for the converter setup block
`timescale 1ns/1ps
module adc_scan_and_pin_config_test;
   localparam int N_IN = 20;
   logic                   mclk;
   logic                   reset_n;
   adc_cfg_pkg::apb_req_t  apb_req;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [1:0]             conv_done;
   logic [1:0]             conv_req;
   logic [31:0]            pin_in;
   logic [31:0]            pin_level;
   logic [31:0]            pin_digital;
   logic [31:0]            mux_ground_c1;
   logic [15:0]            mux_ground_c2;
   logic [31:0]            pin_read;
   adc_cfg_pkg::mux_ctrl_t mux_ctrl_c1;
   adc_cfg_pkg::mux_ctrl_t mux_ctrl_c2;
   int                     n_fail;
   int                     n_checks;
   logic [31:0]            rd;
   logic                   err;
   logic [7:0]             rw_ofs [7];

   adc_scan_and_pin_config #(.NUM_INPUTS(N_IN)) i_adc_scan_and_pin_config (
      .mclk(mclk), .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
      .pin_in(pin_in), .pin_digital(pin_digital),
      .mux_ground_c1(mux_ground_c1), .mux_ground_c2(mux_ground_c2),
      .pin_read(pin_read), .mux_ctrl_c1(mux_ctrl_c1),
      .mux_ctrl_c2(mux_ctrl_c2));

   adc_far_side i_adc_far_side (
      .mclk(mclk), .reset_n(reset_n), .conv_req(conv_req),
      .pin_level(pin_level), .pin_digital(pin_digital),
      .conv_done(conv_done), .pin_in(pin_in));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; waits on pready, takes data at that same edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge mclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: wd};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, "read data");
      chk({31'h0, err}, {31'h0, e}, "read error");
   endtask

   task automatic mux_chk(input int k, input logic [4:0] s,
                          input logic n, input logic sc);
      adc_cfg_pkg::mux_ctrl_t mc;
      mc = (k == 0) ? mux_ctrl_c1 : mux_ctrl_c2;
      chk({25'h0, mc.ch0_pos_sel, mc.neg_ref, mc.scanning},
          {25'h0, s, n, sc}, "channel 0 input");
   endtask

   task automatic scan_step(input int k, input logic [4:0] s,
                            input logic n);
      @(posedge mclk);
      conv_req <= (k == 0) ? 2'b01 : 2'b10;
      @(posedge mclk);
      conv_req <= 2'b00;
      repeat (6) @(posedge mclk);
      mux_chk(k, s, n, 1'b1);
   endtask

   initial begin
      #2_000_000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      rw_ofs = '{adc_cfg_pkg::OFS_C1_SCAN_HIGH, adc_cfg_pkg::OFS_C1_SCAN_LOW,
                 adc_cfg_pkg::OFS_C1_PIN_HIGH, adc_cfg_pkg::OFS_C1_PIN_LOW,
                 adc_cfg_pkg::OFS_C2_SCAN_HIGH, adc_cfg_pkg::OFS_C2_SCAN_LOW,
                 adc_cfg_pkg::OFS_C2_PIN_LOW};
      n_fail = 0;
      n_checks = 0;
      reset_n = 1'b0;
      apb_req = '0;
      conv_req = 2'b00;
      pin_level = 32'hFFFF_FFFF;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;

      // reset values, read/write of every bit of the seven 16 bit registers, refused places
      foreach (rw_ofs[i]) rd_chk(rw_ofs[i], 32'h0000_0000, 1'b0);
      rd_chk(adc_cfg_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
      chk(pin_digital, 32'h0000_0000, "pins analog after reset");
      foreach (rw_ofs[i]) apb(1'b1, rw_ofs[i], 32'hFFFF_FFFF);
      foreach (rw_ofs[i]) rd_chk(rw_ofs[i], 32'h0000_FFFF, 1'b0);
      foreach (rw_ofs[i]) apb(1'b1, rw_ofs[i], 32'h0000_0000);
      rd_chk(adc_cfg_pkg::OFS_C2_PIN_HIGH, 32'h0000_0000, 1'b1);
      apb(1'b1, adc_cfg_pkg::OFS_C2_PIN_HIGH, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h0000_0001, "hole write refused");
      rd_chk(adc_cfg_pkg::OFS_C1_PIN_HIGH, 32'h0000_0000, 1'b0);
      rd_chk(8'h30, 32'h0000_0000, 1'b1);
      apb(1'b1, adc_cfg_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h0000_0001, "status write refused");
      $display("test registers done");

      // pin modes, shared low pins, absent pins, read path
      apb(1'b1, adc_cfg_pkg::OFS_C1_PIN_LOW, 32'h0000_00A5);
      apb(1'b1, adc_cfg_pkg::OFS_C1_PIN_HIGH, 32'h0000_8001);
      apb(1'b1, adc_cfg_pkg::OFS_C2_PIN_LOW, 32'h0000_0100);
      @(posedge mclk);
      chk(pin_digital, 32'h0001_01A5, "digital pins");
      chk(mux_ground_c1, 32'h0001_01A5, "ground c1");
      chk({16'h0, mux_ground_c2}, 32'h0000_01A5, "ground c2");
      repeat (8) @(posedge mclk);
      chk(pin_read, 32'h0001_01A5, "pin read high");
      pin_level <= 32'h0000_0005;
      repeat (8) @(posedge mclk);
      chk(pin_read, 32'h0000_0005, "pin read low");
      $display("test pins done");

      // scan of converter 1: inputs 1, 4, 31 (absent), then wrap
      apb(1'b1, adc_cfg_pkg::OFS_C1_SCAN_LOW, 32'h0000_0012);
      apb(1'b1, adc_cfg_pkg::OFS_C1_SCAN_HIGH, 32'h0000_8000);
      apb(1'b1, adc_cfg_pkg::OFS_CTRL, 32'h0000_0003);
      repeat (3) @(posedge mclk);
      mux_chk(0, 5'd3, 1'b0, 1'b0);
      apb(1'b1, adc_cfg_pkg::OFS_CTRL, 32'h0000_0103);
      repeat (3) @(posedge mclk);
      mux_chk(0, 5'd1, 1'b0, 1'b1);
      scan_step(0, 5'd4, 1'b0);
      scan_step(0, 5'd31, 1'b1);
      rd_chk(adc_cfg_pkg::OFS_STATUS, 32'h0000_007F, 1'b0);
      scan_step(0, 5'd1, 1'b0);

      // scan of converter 2: input 0, then 16 beyond its inputs
      apb(1'b1, adc_cfg_pkg::OFS_C2_SCAN_LOW, 32'h0000_0001);
      apb(1'b1, adc_cfg_pkg::OFS_C2_SCAN_HIGH, 32'h0000_0001);
      apb(1'b1, adc_cfg_pkg::OFS_CTRL, 32'h0100_0103);
      repeat (3) @(posedge mclk);
      mux_chk(1, 5'd0, 1'b0, 1'b1);
      scan_step(1, 5'd16, 1'b1);
      scan_step(1, 5'd0, 1'b0);
      mux_chk(0, 5'd1, 1'b0, 1'b1);
      apb(1'b1, adc_cfg_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      mux_chk(0, 5'd0, 1'b0, 1'b0);
      $display("test scan done");

      // reset in mid run clears everything again
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      chk(pin_digital, 32'h0000_0000, "pins after second reset");
      rd_chk(adc_cfg_pkg::OFS_C1_SCAN_LOW, 32'h0000_0000, 1'b0);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
